// file: hw/tape_density_defines.svh
`ifndef TAPE_DENSITY_DEFINES_SVH
`define TAPE_DENSITY_DEFINES_SVH
// register byte offsets
`define REG_CONFIG      8'h00
`define REG_COMMAND     8'h04
`define REG_STATUS      8'h08
`define REG_SENSE0      8'h10
`define SENSE_WORDS     6
`define SENSE_BYTES     24
// config fields
`define CFG_NRZI9_BIT   0
`define CFG_NRZI7_BIT   1
// command fields
`define CMD_OP_LSB      0
`define CMD_DRV_LSB     4
`define CMD_DEN_LSB     8
// status fields
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_ERR_BIT      2
`define ST_CODE_LSB     8
// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// timing of the resident diagnostic
`define DIAG_TIME_NS    100000
`define CLK_PERIOD_NS   100
`define DIAG_CYCLES     (`DIAG_TIME_NS / `CLK_PERIOD_NS)
// identification values, arbitrary
`define CU_SERIAL       24'h0a0b0c
`define CU_EC_LEVEL     8'h01
`endif

// file: hw/tape_density_pkg.sv
`default_nettype none
package tape_density_pkg;
  typedef enum logic [2:0] {
    DEN_NONE = 3'b000,
    DEN_6250 = 3'b001,
    DEN_1600 = 3'b010,
    DEN_800  = 3'b011,
    DEN_556  = 3'b100,
    DEN_200  = 3'b101
  } density_t;

  typedef enum logic [2:0] {
    OP_NOP      = 3'b000,
    OP_MODE_SET = 3'b001,
    OP_READ     = 3'b010,
    OP_WRITE    = 3'b011,
    OP_SENSE    = 3'b100,
    OP_DIAG     = 3'b101
  } opcode_t;

  typedef enum logic [3:0] {
    ERR_NONE       = 4'h0,
    ERR_NO_NRZI7   = 4'h1,
    ERR_NO_NRZI9   = 4'h2,
    ERR_HD_NO_DUAL = 4'h3,
    ERR_HD_NRZI    = 4'h4,
    ERR_OPT_CLASH  = 4'h5,
    ERR_BAD_DRIVE  = 4'h6,
    ERR_CHANNEL    = 4'h7,
    ERR_MEASURE    = 4'h8,
    ERR_BAD_DEN    = 4'h9,
    ERR_BAD_OP     = 4'ha
  } err_code_t;

  typedef enum logic [1:0] {
    BURST_NONE = 2'b00,
    BURST_6250 = 2'b01,
    BURST_1600 = 2'b10
  } burst_t;

  // state reported by one drive over its own cable
  typedef struct packed {
    logic        present;
    logic        high_density;
    logic        opt_6250_only;
    logic        opt_dual;
    logic        seven_track;
    logic        at_load_point;
    burst_t      id_burst;
    logic        measure_fault;
    logic [15:0] serial;
    logic [7:0]  ec_level;
  } drive_status_t;

  // order sent to the selected drive
  typedef struct packed {
    logic       start;
    logic       write;
    logic [2:0] drive;
    density_t   density;
    logic       write_id_burst;
    logic       correct_single;
    logic       correct_double;
  } drive_cmd_t;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_EXEC   = 2'b01,
    S_DIAG   = 2'b10,
    S_FINISH = 2'b11
  } state_t;
endpackage : tape_density_pkg
`default_nettype wire

// file: hw/density_track.sv
`include "tape_density_defines.svh"
`default_nettype none
module density_track
  import tape_density_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire drive_status_t st,
  input  wire logic          mode_set,
  input  wire density_t      set_density,
  input  wire logic          read_go,
  output var  density_t      write_density,
  output var  density_t      read_mode,
  output var  logic          read_mode_valid
);
  logic lp_q;

  // load point edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) lp_q <= 1'b1; // tape rests at load point, no false edge after reset
    else          lp_q <= st.at_load_point;
  end

  // write density: default on reset or return to load point, else mode set
  always_ff @(posedge aclk) begin
    if (!aresetn || (st.at_load_point && !lp_q)) begin
      write_density <= st.high_density ? DEN_6250 : DEN_1600;
    end else if (mode_set) begin
      write_density <= set_density;
    end
  end

  // read mode from the id burst, kept until tape is back at load point
  always_ff @(posedge aclk) begin
    if (!aresetn || (st.at_load_point && !lp_q)) begin
      read_mode       <= DEN_NONE;
      read_mode_valid <= 1'b0;
    end else if (read_go && !read_mode_valid) begin
      read_mode_valid <= 1'b1;
      unique case (st.id_burst)
        BURST_6250: read_mode <= DEN_6250;
        BURST_1600: read_mode <= DEN_1600;
        default:    read_mode <= st.seven_track ? write_density : DEN_800;
      endcase
    end
  end
endmodule : density_track
`default_nettype wire

// file: hw/tape_density_mode_control.sv
`include "tape_density_defines.svh"
`default_nettype none
module tape_density_mode_control
  import tape_density_pkg::*;
#(
  parameter int NUM_DRIVES = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          channel_block_mode,
  input  wire drive_status_t drive_st [NUM_DRIVES],
  output drive_cmd_t         drive_cmd
);
  logic [1:0]          config_q;
  logic [31:0]         command_q;
  logic                busy_q, done_q, error_q, cmd_go_q;
  err_code_t           err_code_q;
  state_t              state_q;
  logic [9:0]          diag_cnt_q;
  logic                diag_fail_q;
  logic [7:0]          fault_map_q;
  logic [7:0]          cmd_count_q;
  err_code_t           prev_err_q;
  logic [7:0]          sense_q [`SENSE_BYTES];
  logic                aw_held_q, w_held_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  drive_cmd_t          cmd_q;
  logic [NUM_DRIVES-1:0] mode_set_v, read_go_v, rvalid_v;
  density_t            wden_v [NUM_DRIVES];
  density_t            rmode_v [NUM_DRIVES];
  err_code_t           exec_err;
  logic                wr_fire;

  // command fields
  opcode_t    op;
  logic [2:0] drv;
  density_t   den;
  logic       opt9, opt7;
  assign op   = opcode_t'(command_q[`CMD_OP_LSB +: 3]);
  assign drv  = command_q[`CMD_DRV_LSB +: 3];
  assign den  = density_t'(command_q[`CMD_DEN_LSB +: 3]);
  assign opt9 = config_q[`CFG_NRZI9_BIT];
  assign opt7 = config_q[`CFG_NRZI7_BIT] & opt9;

  drive_status_t sel;
  logic          drv_ok;
  assign drv_ok = ({29'h0, drv} < NUM_DRIVES);
  assign sel    = drv_ok ? drive_st[drv] : '0;

  // one mode tracker per radially cabled drive
  for (genvar i = 0; i < NUM_DRIVES; i++) begin : g_drv
    assign mode_set_v[i] = (state_q == S_EXEC) && (op == OP_MODE_SET) && (drv == 3'(i)) && (exec_err == ERR_NONE);
    assign read_go_v[i]  = (state_q == S_EXEC) && (op == OP_READ) && (drv == 3'(i)) && (exec_err == ERR_NONE);
    density_track u_track (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .st              (drive_st[i]),
      .mode_set        (mode_set_v[i]),
      .set_density     (den),
      .read_go         (read_go_v[i]),
      .write_density   (wden_v[i]),
      .read_mode       (rmode_v[i]),
      .read_mode_valid (rvalid_v[i])
    );
  end

  // density needed by a read: held mode, or what the burst will select
  density_t rd_den;
  always_comb begin
    if (drv_ok && rvalid_v[drv])       rd_den = rmode_v[drv];
    else if (sel.id_burst == BURST_6250) rd_den = DEN_6250;
    else if (sel.id_burst == BURST_1600) rd_den = DEN_1600;
    else if (sel.seven_track && drv_ok) rd_den = wden_v[drv];
    else                                rd_den = DEN_800;
  end

  // check a density against drive type and installed options
  function automatic err_code_t den_check(input drive_status_t s, input density_t d);
    err_code_t e;
    e = ERR_NONE;
    unique case (d)
      DEN_6250: if (!s.high_density) e = ERR_BAD_DEN;
      DEN_1600: begin
        if (s.high_density && !s.opt_dual) e = ERR_HD_NO_DUAL;
        else if (s.seven_track) e = ERR_BAD_DEN;
      end
      DEN_800: begin
        if (s.high_density) e = ERR_HD_NRZI;
        else if (s.seven_track ? !opt7 : !opt9) e = s.seven_track ? ERR_NO_NRZI7 : ERR_NO_NRZI9;
      end
      DEN_556, DEN_200: begin
        if (s.high_density) e = ERR_HD_NRZI;
        else if (!s.seven_track || !opt7) e = ERR_NO_NRZI7;
      end
      default: e = ERR_BAD_DEN;
    endcase
    // seven-track tape of any density needs the seven-track option
    if (s.seven_track && !s.high_density && !opt7) e = ERR_NO_NRZI7;
    return e;
  endfunction : den_check

  // error decision for the command under execution
  always_comb begin
    exec_err = ERR_NONE;
    if (!channel_block_mode) exec_err = ERR_CHANNEL;
    else if (op == OP_SENSE || op == OP_DIAG || op == OP_NOP) exec_err = ERR_NONE;
    else if (op > OP_DIAG) exec_err = ERR_BAD_OP;
    else if (!drv_ok || !sel.present) exec_err = ERR_BAD_DRIVE;
    else if (sel.high_density && sel.opt_6250_only && sel.opt_dual) exec_err = ERR_OPT_CLASH;
    else if (op == OP_MODE_SET) exec_err = den_check(sel, den);
    else if (op == OP_READ) exec_err = den_check(sel, rd_den);
    else exec_err = den_check(sel, wden_v[drv]);
  end

  // operation sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE:   if (cmd_go_q) state_q <= S_EXEC;
        S_EXEC:   state_q <= (op == OP_DIAG && exec_err == ERR_NONE) ? S_DIAG : S_FINISH;
        S_DIAG:   if (diag_cnt_q == 10'(`DIAG_CYCLES - 1)) state_q <= S_FINISH;
        S_FINISH: state_q <= S_IDLE;
      endcase
    end
  end

  // resident diagnostic: timed watch of every drive's configuration
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != S_DIAG) begin
      diag_cnt_q <= 10'h0;
    end else begin
      diag_cnt_q <= diag_cnt_q + 10'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == S_EXEC) begin
      diag_fail_q <= 1'b0;
    end else if (state_q == S_DIAG) begin
      for (int i = 0; i < NUM_DRIVES; i++) begin
        if (drive_st[i].present && (drive_st[i].measure_fault ||
            (drive_st[i].opt_6250_only && drive_st[i].opt_dual))) begin
          diag_fail_q <= 1'b1;
        end
      end
    end
  end

  // sticky drive measurement fault map, set wins over sense clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_map_q <= 8'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i < NUM_DRIVES && drive_st[i].present && drive_st[i].measure_fault) fault_map_q[i] <= 1'b1;
        else if (state_q == S_FINISH && op == OP_SENSE) fault_map_q[i] <= 1'b0;
      end
    end
  end

  // command status and error ending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      error_q     <= 1'b0;
      err_code_q  <= ERR_NONE;
      prev_err_q  <= ERR_NONE;
      cmd_count_q <= 8'h0;
    end else begin
      if (cmd_go_q) busy_q <= 1'b1;
      if (state_q == S_EXEC) begin
        prev_err_q  <= err_code_q;
        err_code_q  <= exec_err;
        cmd_count_q <= cmd_count_q + 8'h1;
      end
      if (state_q == S_DIAG && diag_fail_q && err_code_q == ERR_NONE) err_code_q <= ERR_MEASURE;
      if (state_q == S_FINISH) begin
        busy_q  <= 1'b0;
        done_q  <= 1'b1;
        error_q <= (err_code_q != ERR_NONE) || diag_fail_q;
      end else if (wr_fire && awaddr_q == `REG_STATUS && wstrb_q[0] && wdata_q[`ST_DONE_BIT]) begin
        done_q  <= 1'b0;
        error_q <= 1'b0;
      end
    end
  end

  // drive order, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= '0;
    end else begin
      cmd_q.start          <= 1'b0;
      cmd_q.write_id_burst <= 1'b0;
      if (state_q == S_EXEC && exec_err == ERR_NONE && (op == OP_READ || op == OP_WRITE)) begin
        cmd_q.start          <= 1'b1;
        cmd_q.write          <= (op == OP_WRITE);
        cmd_q.drive          <= drv;
        cmd_q.density        <= (op == OP_WRITE) ? wden_v[drv] : rd_den;
        cmd_q.write_id_burst <= (op == OP_WRITE) && sel.at_load_point &&
                                (wden_v[drv] == DEN_6250 || wden_v[drv] == DEN_1600);
        cmd_q.correct_single <= (op == OP_READ) && (rd_den == DEN_6250 || rd_den == DEN_1600);
        cmd_q.correct_double <= (op == OP_READ) && (rd_den == DEN_6250);
      end
    end
  end
  assign drive_cmd = cmd_q;

  // sense block captured at the end of every command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `SENSE_BYTES; i++) sense_q[i] <= 8'h0;
    end else if (state_q == S_FINISH) begin
      sense_q[0]  <= {3'h0, err_code_q == ERR_CHANNEL, err_code_q == ERR_OPT_CLASH,
                      err_code_q != ERR_NONE, |fault_map_q, diag_fail_q};
      sense_q[1]  <= {4'h0, err_code_q};
      sense_q[2]  <= {5'h0, drv};
      sense_q[3]  <= {5'h0, drv_ok ? wden_v[drv] : DEN_NONE};
      sense_q[4]  <= {4'h0, drv_ok && rvalid_v[drv], drv_ok ? rmode_v[drv] : DEN_NONE};
      sense_q[5]  <= {6'h0, config_q};
      sense_q[6]  <= {3'h0, sel.present, sel.high_density, sel.opt_6250_only, sel.opt_dual, sel.seven_track};
      sense_q[7]  <= fault_map_q;
      sense_q[8]  <= 8'(`CU_SERIAL >> 16);
      sense_q[9]  <= 8'(`CU_SERIAL >> 8);
      sense_q[10] <= 8'(`CU_SERIAL);
      sense_q[11] <= `CU_EC_LEVEL;
      sense_q[12] <= sel.serial[15:8];
      sense_q[13] <= sel.serial[7:0];
      sense_q[14] <= sel.ec_level;
      sense_q[15] <= {7'h0, diag_fail_q};
      sense_q[16] <= {5'h0, op};
      sense_q[17] <= {4'h0, prev_err_q};
      sense_q[18] <= cmd_count_q;
      sense_q[19] <= {6'h0, state_q};
      for (int i = 20; i < `SENSE_BYTES; i++) sense_q[i] <= 8'h0;
    end
  end

  // axi write: address and data taken in either order
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // ready flags registered so outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // register writes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q     <= 2'h0;
      command_q    <= 32'h0;
      cmd_go_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      cmd_go_q <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        unique case (awaddr_q)
          `REG_CONFIG: if (wstrb_q[0]) config_q <= wdata_q[1:0];
          `REG_COMMAND: begin
            if (!busy_q && !cmd_go_q && (&wstrb_q[1:0])) begin
              command_q <= {20'h0, wdata_q[11:0]};
              cmd_go_q  <= 1'b1;
            end
          end
          `REG_STATUS: ;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // axi read: answer one cycle after the address is taken
  logic [5:0] sw;
  assign sw = 6'((s_axi_araddr - `REG_SENSE0) >> 2); // wide enough that no address aliases a sense word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0;
        if (s_axi_araddr == `REG_CONFIG) s_axi_rdata <= {30'h0, config_q};
        else if (s_axi_araddr == `REG_COMMAND) s_axi_rdata <= command_q;
        else if (s_axi_araddr == `REG_STATUS)
          s_axi_rdata <= {20'h0, err_code_q, 5'h0, error_q, done_q, busy_q};
        else if (s_axi_araddr >= `REG_SENSE0 && s_axi_araddr[1:0] == 2'h0 && sw < `SENSE_WORDS)
          s_axi_rdata <= {sense_q[4*sw+3], sense_q[4*sw+2], sense_q[4*sw+1], sense_q[4*sw]};
        else s_axi_rresp <= `RESP_SLVERR;
      end
    end
  end
endmodule : tape_density_mode_control
`default_nettype wire

// file: verif/tape_density_mode_control_properties.sv
`default_nettype none
module tape_density_mode_control_properties
  import tape_density_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        channel_block_mode,
  input wire drive_cmd_t  drive_cmd
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // address and data taken together
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // command write while on a byte channel
  sequence s_cmd_byte;
    s_wr_taken ##0 (s_axi_awaddr == 8'h04 && !channel_block_mode);
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) // held one cycle, then answered
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  a_ready_pending: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while response pending");
  a_start_single: assert property (drive_cmd.start |=> !drive_cmd.start)
    else $error("start longer than one cycle");
  a_burst_on_write: assert property (drive_cmd.write_id_burst |-> drive_cmd.start && drive_cmd.write)
    else $error("id burst outside write start");
  a_gc_correct: assert property (drive_cmd.start && !drive_cmd.write && drive_cmd.density == DEN_6250
      |-> drive_cmd.correct_single && drive_cmd.correct_double)
    else $error("group coded read without correction");
  a_byte_channel: assert property (s_cmd_byte |=> !drive_cmd.start [*6])
    else $error("drive started from byte channel");
endmodule : tape_density_mode_control_properties

bind tape_density_mode_control tape_density_mode_control_properties chk_u (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .channel_block_mode, .drive_cmd);
`default_nettype wire

// file: verif/tape_drive_model.sv
`default_nettype none
module tape_drive_model
  import tape_density_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire drive_cmd_t    drive_cmd,
  input  wire drive_status_t base [8],
  output var  drive_status_t drive_st [8]
);
  timeunit 1ns;
  timeprecision 1ns;
  burst_t     burst_q [8];
  logic [7:0] lp_q;

  // one cable per drive, own tape position and id burst
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (!aresetn) begin
        lp_q[i]    <= 1'b1;
        burst_q[i] <= base[i].id_burst;
      end else if (drive_cmd.start && drive_cmd.drive == 3'(i)) begin
        lp_q[i] <= 1'b0;
        if (drive_cmd.write_id_burst) begin
          burst_q[i] <= (drive_cmd.density == DEN_6250) ? BURST_6250 : BURST_1600;
        end
      end
    end
  end

  // status lines seen by the control unit
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drive_st[i]               = base[i];
      drive_st[i].at_load_point = lp_q[i];
      drive_st[i].id_burst      = burst_q[i];
    end
  end
endmodule : tape_drive_model
`default_nettype wire

// file: verif/tape_density_mode_control_tb_top.sv
`include "tape_density_defines.svh"
`default_nettype none
module tape_density_mode_control_tb_top
  import tape_density_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, channel_block_mode;
  logic [7:0]    s_axi_awaddr, s_axi_araddr, moved;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  drive_status_t base [8], drive_st [8];
  drive_cmd_t    drive_cmd;
  logic [33:0]   exp_v [$], exp_m [$];
  logic [7:0]    exp_c [$];
  int            n_fail, samples_checked, seed;

  tape_density_mode_control #(.NUM_DRIVES(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .channel_block_mode, .drive_st, .drive_cmd);
  tape_drive_model drv_u (.aclk, .aresetn, .drive_cmd, .base, .drive_st);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [33:0] seen, exp, msk);
    samples_checked++;
    if ((seen & msk) !== (exp & msk)) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp & msk, seen & msk);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // compares each answer with the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      check("bresp", {s_axi_bresp, 32'h0}, exp_v.pop_front(), exp_m.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      check("rdata", {s_axi_rresp, s_axi_rdata}, exp_v.pop_front(), exp_m.pop_front());
    end
    if (drive_cmd.start) check("order", {26'h0, drive_cmd.write, drive_cmd.drive, drive_cmd.density,
      drive_cmd.write_id_burst}, {26'h0, exp_c.pop_front()}, 34'hff);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    exp_v.push_back({2'h0, 32'h0});
    exp_m.push_back(34'h300000000);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (n == 1) s_axi_bready <= 1'b1;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) begin n_fail++; tally_and_finish(); end
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] v, m);
    int n;
    exp_v.push_back(v);
    exp_m.push_back(m);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (n == 1) s_axi_rready <= 1'b1;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) begin n_fail++; tally_and_finish(); end
    @(posedge aclk);
  endtask : rd

  // one command: clear, issue, wait, check status
  task automatic run(input opcode_t op, input logic [2:0] dv, input density_t den, input err_code_t code,
                     input density_t xden, input int hold);
    wr(8'h08, 32'h2);
    if (code == ERR_NONE && (op == OP_READ || op == OP_WRITE)) begin
      exp_c.push_back({op == OP_WRITE, dv, xden, op == OP_WRITE && !moved[dv]});
      moved[dv] = 1'b1;
    end
    wr(8'h04, {21'h0, den, 1'b0, dv, 1'b0, op});
    repeat (hold) @(posedge aclk);
    rd(8'h08, {22'h0, code, 5'h0, code != ERR_NONE, 2'b10}, 34'h300000f07);
  endtask : run

  initial begin
    seed = 75305;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {channel_block_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata, moved} = '0;
    s_axi_wstrb = 4'hf;
    foreach (base[i]) begin
      base[i] = '0;
      base[i].present = 1'b1;
      base[i].high_density = (i < 6);
      base[i].opt_dual = (i < 3 || i == 5);
      base[i].opt_6250_only = (i > 2 && i < 6);
      base[i].seven_track = (i == 6);
    end
    base[1].id_burst = BURST_1600;
    base[3].id_burst = BURST_6250;
    base[4].id_burst = BURST_1600;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(8'h40, {2'h2, 32'h0}, 34'h3ffffffff);
    run(OP_READ, 3'd1, DEN_NONE, ERR_CHANNEL, DEN_NONE, 8);
    channel_block_mode <= 1'b1;
    run(OP_WRITE, 3'd0, DEN_NONE, ERR_NONE, DEN_6250, 8);
    run(OP_READ, 3'd2, DEN_NONE, ERR_HD_NRZI, DEN_NONE, 8);
    run(OP_MODE_SET, 3'd2, DEN_1600, ERR_NONE, DEN_NONE, 8);
    run(OP_WRITE, 3'd2, DEN_NONE, ERR_NONE, DEN_1600, 8);
    run(OP_READ, 3'd1, DEN_NONE, ERR_NONE, DEN_1600, 8);
    run(OP_READ, 3'd3, DEN_NONE, ERR_NONE, DEN_6250, 8);
    run(OP_READ, 3'd4, DEN_NONE, ERR_HD_NO_DUAL, DEN_NONE, 8);
    run(OP_READ, 3'd5, DEN_NONE, ERR_OPT_CLASH, DEN_NONE, 8);
    run(OP_READ, 3'd7, DEN_NONE, ERR_NO_NRZI9, DEN_NONE, 8);
    wr(8'h00, 32'h1);
    rd(8'h00, {2'h0, 32'h1}, 34'h300000003);
    run(OP_READ, 3'd6, DEN_NONE, ERR_NO_NRZI7, DEN_NONE, 8);
    run(OP_READ, 3'd7, DEN_NONE, ERR_NONE, DEN_800, 8);
    wr(8'h00, 32'h3);
    for (int k = 0; k < 3; k++) run(OP_MODE_SET, 3'd6, density_t'(3 + k), ERR_NONE, DEN_NONE, 8);
    run(OP_MODE_SET, 3'd6, density_t'(6 + ($random(seed) & 1)), ERR_BAD_DEN, DEN_NONE, 8);
    rd(8'h10, {22'h0, 4'h9, 8'h0}, 34'h30000ff00);
    rd(8'h18, {2'h0, `CU_EC_LEVEL, 24'h0}, 34'h3ff000000);
    rd(8'h24, 34'h0, 34'h3ffffffff);
    run(OP_SENSE, 3'd0, DEN_NONE, ERR_NONE, DEN_NONE, 8);
    run(opcode_t'(3'h6), 3'd0, DEN_NONE, ERR_BAD_OP, DEN_NONE, 8);
    // drive 5 carries both high-density options, so the diagnostic reports a fault
    run(OP_DIAG, 3'd0, DEN_NONE, ERR_MEASURE, DEN_NONE, 1015);
    tally_and_finish();
  end
endmodule : tape_density_mode_control_tb_top
`default_nettype wire
